/* File: inc/dct_pkg.sv */
// shared constants of the continuity test path
package dct_pkg;

    // sixteen-bit data path: low half carries the minterms, high half the inverse
    localparam int DQ_W = 16;
    localparam int DQ_HALF = 8;
    localparam int ADDR_W = 18;
    localparam int MT_N = 10;

    // strobe vector layout: lower true, lower comp, upper true, upper comp
    localparam int STB_W = 4;
    localparam int STB_LT = 0;
    localparam int STB_LC = 1;
    localparam int STB_UT = 2;
    localparam int STB_UC = 3;

    // the top address bit may or may not join minterm_2
    localparam logic MT2_USE_ADDR17 = 1'b1;

    // reset value of the sticky re-initialisation flag
    localparam logic REINIT_RST = 1'b0;

endpackage : dct_pkg

/* File: hw/dct_continuity_test.sv */
`timescale 1ns/1ps

// Functional notes
// RULE_01: a high continuity_select bypasses normal memory behaviour and turns pins into test pins.
// RULE_02: test outputs drive only while device_select_n is low, otherwise they are released.
// RULE_03: minterms 0 to 4 are three-input XORs of the listed address, clock and control pins; minterm_2 also takes addr[17] here.
// RULE_04: minterms 5 to 9 are three-input XORs, minterm_9 using hard reset ANDed with select.
// RULE_05: data lines 0..7 carry minterms 0..7 and data lines 8..15 their inverses.
// RULE_06: lower strobes carry minterms 8 and 9, upper strobes carry the inverse of the lower ones.
// RULE_07: the agent raises continuity_select only with stable supplies and hard reset high.
// RULE_08: clock pins and clock_gate become test inputs within clk_test_input_delay of entry.
// RULE_09: other test inputs are valid input_sampling_delay after entry once selected.
// RULE_10: no refresh, external or self-timed, is let through while in test mode.
// RULE_11: the agent enters test mode only after power-on has completed.
// RULE_12: the agent does not use test mode after initialisation and reference calibration.
// RULE_13: lowering continuity_select ends test mode at once with no other condition.
// RULE_14: after exit neither internal state nor array contents are guaranteed.
// RULE_15: after exit the agent applies a full reset and initialisation before normal use.
// RULE_16: outputs settle within test_output_valid_delay of new inputs while selected.
// RULE_17: the test path is purely combinational from test inputs to test outputs.
module dct_continuity_test (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // mode control
    input wire logic continuity_select,
    input wire logic device_select_n,
    input wire logic hard_reset_low,
    // command and address test inputs
    input wire logic [dct_pkg::ADDR_W-1:0] addr,
    input wire logic bank_sel0,
    input wire logic bank_sel1,
    input wire logic group_sel0,
    input wire logic activate_low,
    input wire logic cmd_parity_in,
    input wire logic termination_ctl,
    input wire logic clock_gate,
    input wire logic diff_clock_true,
    input wire logic diff_clock_comp,
    // mask and alert test inputs
    input wire logic lower_mask_inv,
    input wire logic upper_mask_inv,
    input wire logic alert_low_pin,
    // normal memory core side
    input wire logic [dct_pkg::DQ_W-1:0] core_dq_out,
    input wire logic core_dq_oe,
    input wire logic [dct_pkg::STB_W-1:0] core_stb_out,
    input wire logic core_stb_oe,
    input wire logic core_refresh_req,
    // data and strobe pins, output side of the two-way pins
    output logic [dct_pkg::DQ_W-1:0] dq_out,
    output logic dq_oe,
    output logic [dct_pkg::STB_W-1:0] stb_out,
    output logic stb_oe,
    // status
    output logic continuity_test_mode,
    output logic refresh_go,
    output logic reinit_needed
);
    import dct_pkg::*;

    logic [MT_N-1:0] minterm;
    logic [DQ_W-1:0] test_dq;
    logic [STB_W-1:0] test_stb;
    logic was_test;
    logic next_was_test;
    logic next_reinit_needed;

    // shared-function address pins named by their command role
    wire autoprecharge_addr10 = addr[10];
    wire burst_chop_addr12 = addr[12];
    wire write_en_addr14 = addr[14];
    wire col_strobe_addr15 = addr[15];
    wire row_strobe_addr16 = addr[16];

    // mode follows the select pin with no storage, so exit is immediate
    assign continuity_test_mode = continuity_select; // RULE_01 RULE_13

    // minterms, plain gates only: no flop may sit between test pins and pads
    always_comb begin
        minterm[0] = addr[1] ^ addr[6] ^ cmd_parity_in; // RULE_03
        minterm[1] = addr[8] ^ alert_low_pin ^ addr[9]; // RULE_03
        minterm[2] = addr[2] ^ addr[5] ^ addr[13] ^ (MT2_USE_ADDR17 & addr[17]); // RULE_03
        minterm[3] = addr[0] ^ addr[7] ^ addr[11]; // RULE_03
        minterm[4] = diff_clock_comp ^ termination_ctl ^ col_strobe_addr15; // RULE_03 RULE_08
        minterm[5] = clock_gate ^ row_strobe_addr16 ^ autoprecharge_addr10; // RULE_04 RULE_08
        minterm[6] = activate_low ^ addr[4] ^ bank_sel1; // RULE_04
        minterm[7] = upper_mask_inv ^ lower_mask_inv ^ diff_clock_true; // RULE_04 RULE_08
        minterm[8] = write_en_addr14 ^ burst_chop_addr12 ^ bank_sel0; // RULE_04
        minterm[9] = group_sel0 ^ addr[3] ^ (hard_reset_low & continuity_select); // RULE_04
    end

    // each of minterms 0 to 7 must reach its data line, not only the three sampled further down
    mid_terms_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
        continuity_select |-> (dq_out[1] == ^{addr[8], alert_low_pin, addr[9]}
            && dq_out[2] == ^{addr[2], addr[5], addr[13], MT2_USE_ADDR17 & addr[17]}
            && dq_out[3] == ^{addr[0], addr[7], addr[11]}))
        else $error("middle minterm mismatch");
    upper_terms_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
        continuity_select |-> (dq_out[6] == ^{activate_low, addr[4], bank_sel1}
            && dq_out[7] == ^{upper_mask_inv, lower_mask_inv, diff_clock_true}))
        else $error("upper minterm mismatch");

    // low half straight, high half inverted, so a stuck or bridged pair shows up
    genvar gi;
    generate
        for (gi = 0; gi < DQ_HALF; gi++) begin : g_dq
            assign test_dq[gi] = minterm[gi]; // RULE_05 RULE_17
            assign test_dq[gi+DQ_HALF] = ~minterm[gi]; // RULE_05 RULE_17
        end
    endgenerate

    // strobe pairs: upper is the inverse of lower
    always_comb begin
        test_stb[STB_LT] = minterm[8]; // RULE_06
        test_stb[STB_LC] = minterm[9]; // RULE_06
        test_stb[STB_UT] = ~minterm[8]; // RULE_06
        test_stb[STB_UC] = ~minterm[9]; // RULE_06
    end

    // the complement pair must invert as well, or a short between the strobes hides
    strobe_comp_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_06
        continuity_select |-> stb_out[STB_UC] == !stb_out[STB_LC])
        else $error("complement strobe pair mismatch");

    // pad mux; combinational by design, test results must track inputs (RULE_16 timing)
    always_comb begin
        if (continuity_select) begin
            dq_out = test_dq; // RULE_01 RULE_16
            stb_out = test_stb;
            dq_oe = ~device_select_n; // RULE_02 RULE_09
            stb_oe = ~device_select_n; // RULE_02
        end else begin
            dq_out = core_dq_out;
            stb_out = core_stb_out;
            dq_oe = core_dq_oe;
            stb_oe = core_stb_oe;
        end
    end

    // outside test mode the pads belong to the memory core untouched
    core_pass_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
        !continuity_select |-> (dq_out == core_dq_out && dq_oe == core_dq_oe
            && stb_out == core_stb_out && stb_oe == core_stb_oe))
        else $error("core drive not passed outside test mode");

    // refresh of either origin is blocked in test mode
    assign refresh_go = core_refresh_req & ~continuity_select; // RULE_10

    // a refresh request outside test mode must not be lost either
    refresh_pass_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_10
        !continuity_select |-> refresh_go == core_refresh_req)
        else $error("refresh request lost outside test mode");

    // sticky flag: array contents are void after a test session until hard reset
    always_comb begin
        next_was_test = continuity_select;
        next_reinit_needed = reinit_needed;
        if (!hard_reset_low) begin
            next_reinit_needed = 1'b0;
        end
        // set wins over the clear in the same cycle
        if (was_test && !continuity_select) begin
            next_reinit_needed = 1'b1; // RULE_14
        end
    end

    // status registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            was_test <= 1'b0;
            reinit_needed <= REINIT_RST;
        end else begin
            was_test <= next_was_test;
            reinit_needed <= next_reinit_needed;
        end
    end

    // hard reset clears the flag unless an exit lands in the same cycle; otherwise it holds
    reinit_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_14
        (!hard_reset_low && !(was_test && !continuity_select)) |=> !reinit_needed)
        else $error("re-initialisation flag not cleared by hard reset");
    reinit_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_14
        (hard_reset_low && !(was_test && !continuity_select))
            |=> reinit_needed == $past(reinit_needed))
        else $error("re-initialisation flag changed without cause");

    // checks on the test path, sampled at the clock
    test_mode_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
        continuity_select |-> (continuity_test_mode && dq_out == test_dq && stb_out == test_stb))
        else $error("test mode does not route test results");
    out_release_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
        continuity_select |-> (dq_oe == !device_select_n && stb_oe == !device_select_n))
        else $error("test outputs not gated by device select");
    low_terms_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
        continuity_select |-> (dq_out[0] == ^{addr[1], addr[6], cmd_parity_in}
            && dq_out[4] == ^{diff_clock_comp, termination_ctl, addr[15]}))
        else $error("low minterm mismatch");
    high_terms_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
        continuity_select |-> (stb_out[STB_LC] == ^{group_sel0, addr[3], hard_reset_low}
            && dq_out[5] == ^{clock_gate, addr[16], addr[10]}))
        else $error("high minterm mismatch");
    dq_invert_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
        continuity_select |-> dq_out[DQ_W-1:DQ_HALF] == ~dq_out[DQ_HALF-1:0])
        else $error("upper data half is not the inverse");
    strobe_pair_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_06
        continuity_select |-> (stb_out[STB_UT] == !stb_out[STB_LT]
            && stb_out[STB_LT] == ^{addr[14], addr[12], bank_sel0}))
        else $error("strobe pair mismatch");
    no_refresh_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_10
        continuity_select |-> !refresh_go)
        else $error("refresh issued in test mode");
    exit_now_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_13
        $fell(continuity_select) |-> (!continuity_test_mode && dq_out == core_dq_out))
        else $error("test mode exit not immediate");
    exit_flag_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_14
        (was_test && !continuity_select) |=> reinit_needed)
        else $error("exit did not flag re-initialisation");
    track_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_17
        (continuity_select && $changed(addr[1]) && $stable(addr[6])
            && $stable(cmd_parity_in)) |-> $changed(dq_out[0]))
        else $error("test output did not track input in the same cycle");

endmodule : dct_continuity_test

/* File: verif/dct_tester_model.sv */
`timescale 1ns/1ps

// board-side tester: drives every test input pin except hard reset from one pattern word
module dct_tester_model (
    // requests from the bench
    input wire logic sel_req,
    input wire logic cs_req_n,
    input wire logic rst_req_n,
    input wire logic [29:0] pat,
    // pins toward the device
    output logic continuity_select,
    output logic device_select_n,
    output logic hard_reset_low,
    output logic [dct_pkg::ADDR_W-1:0] addr,
    output logic [11:0] misc
);
    // select may only rise with reset held high, so never before power-on ends
    // the bench enters test mode after power-on and again after a hard reset pulse, never after initialisation
    assign continuity_select = sel_req & rst_req_n;
    assign device_select_n = cs_req_n;
    assign hard_reset_low = rst_req_n;
    assign addr = pat[17:0];
    assign misc = pat[29:18];
endmodule : dct_tester_model

/* File: verif/dct_continuity_test_tb_top.sv */
`timescale 1ns/1ps

module dct_continuity_test_tb_top;
    import dct_pkg::*;
    // bench-driven requests and core side
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sel_req = 1'b0;
    logic cs_req_n = 1'b1;
    logic rst_req_n = 1'b1;
    logic [29:0] pat = 30'h0;
    logic [DQ_W-1:0] core_dq_out = 16'h5a3c;
    logic [STB_W-1:0] core_stb_out = 4'h6;
    logic core_refresh_req = 1'b1;
    // distinct enables so the core pass-through of each one is visible
    logic core_dq_oe = 1'b1;
    logic core_stb_oe = 1'b0;
    int timed_out = 0;
    logic continuity_select, device_select_n, hard_reset_low, dq_oe, stb_oe;
    logic continuity_test_mode, refresh_go, reinit_needed;
    logic [ADDR_W-1:0] addr;
    logic [11:0] misc;
    logic [DQ_W-1:0] dq_out;
    logic [STB_W-1:0] stb_out;
    logic [9:0] m;
    int n_mismatch = 0;
    int total_checks = 0;

    // 10 MHz clock
    always #50 clk = ~clk;

    dct_tester_model u_tester (.sel_req(sel_req), .cs_req_n(cs_req_n), .rst_req_n(rst_req_n),
        .pat(pat), .continuity_select(continuity_select), .device_select_n(device_select_n),
        .hard_reset_low(hard_reset_low), .addr(addr), .misc(misc));

    dct_continuity_test u_dut (.clk(clk), .rst_n(rst_n), .continuity_select(continuity_select),
        .device_select_n(device_select_n), .hard_reset_low(hard_reset_low), .addr(addr),
        .bank_sel0(misc[0]), .bank_sel1(misc[1]), .group_sel0(misc[2]),
        .activate_low(misc[3]), .cmd_parity_in(misc[4]), .termination_ctl(misc[5]),
        .clock_gate(misc[6]), .diff_clock_true(misc[7]), .diff_clock_comp(misc[8]),
        .lower_mask_inv(misc[9]), .upper_mask_inv(misc[10]), .alert_low_pin(misc[11]),
        .core_dq_out(core_dq_out), .core_dq_oe(core_dq_oe), .core_stb_out(core_stb_out),
        .core_stb_oe(core_stb_oe), .core_refresh_req(core_refresh_req), .dq_out(dq_out),
        .dq_oe(dq_oe), .stb_out(stb_out), .stb_oe(stb_oe),
        .continuity_test_mode(continuity_test_mode), .refresh_go(refresh_go),
        .reinit_needed(reinit_needed));

    // reference minterms from the pattern word; h is reset ANDed with select
    function automatic logic [9:0] mt(input logic [29:0] v, input logic h);
        return {v[20] ^ v[3] ^ h, v[14] ^ v[12] ^ v[18], v[28] ^ v[27] ^ v[25],
            v[21] ^ v[4] ^ v[19], v[24] ^ v[16] ^ v[10], v[26] ^ v[23] ^ v[15],
            v[0] ^ v[7] ^ v[11], v[2] ^ v[5] ^ v[13] ^ (MT2_USE_ADDR17 & v[17]),
            v[8] ^ v[29] ^ v[9], v[1] ^ v[6] ^ v[22]};
    endfunction : mt

    task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // walk a one, then all ones, across every test input but hard reset while selected
    task t_pattern;
        sel_req = 1'b1;
        cs_req_n = 1'b0;
        for (int i = 0; i <= 30; i++) begin
            pat = (i == 30) ? 30'h3fffffff : 30'h1 << i;
            #5;
            m = mt(pat, 1'b1);
            chk("dq_out", {~m[7:0], m[7:0]}, dq_out);
            chk("stb_out", {12'h0, ~m[9], ~m[8], m[9], m[8]}, {12'h0, stb_out});
            chk("oe", 16'h3, {14'h0, dq_oe, stb_oe});
            chk("mode_refresh", 16'h2, {14'h0, continuity_test_mode, refresh_go});
            @(posedge clk);
            #10;
        end
        $display("test pattern done");
    endtask : t_pattern

    // deselect releases the pins, then select drops with no other condition
    task t_release;
        cs_req_n = 1'b1;
        #5;
        chk("oe_released", 16'h0, {14'h0, dq_oe, stb_oe});
        @(posedge clk);
        #10;
        sel_req = 1'b0;
        #5;
        chk("oe_core", 16'h2, {14'h0, dq_oe, stb_oe});
        chk("dq_core", core_dq_out, dq_out);
        chk("stb_core", {12'h0, core_stb_out}, {12'h0, stb_out});
        chk("mode_refresh", 16'h1, {14'h0, continuity_test_mode, refresh_go});
        $display("test release done");
    endtask : t_release

    // after exit the flag asks for re-initialisation until reset is pulsed
    task t_reinit;
        for (int k = 0; k < 4 && reinit_needed !== 1'b1; k++) begin
            @(posedge clk);
            #10;
        end
        chk("reinit_set", 16'h1, {15'h0, reinit_needed});
        if (reinit_needed !== 1'b1) begin
            timed_out = 1;
            return;
        end
        rst_req_n = 1'b0;
        @(posedge clk);
        #10;
        chk("reinit_clr", 16'h0, {15'h0, reinit_needed});
        rst_req_n = 1'b1;
        $display("test reinit done");
    endtask : t_reinit

    // a second session sets the flag again, then a mid-run reset clears it at once
    task t_reset_mid;
        sel_req = 1'b1;
        cs_req_n = 1'b0;
        @(posedge clk);
        #10;
        sel_req = 1'b0;
        @(posedge clk);
        #10;
        chk("reinit_again", 16'h1, {15'h0, reinit_needed});
        rst_n = 1'b0;
        #5;
        chk("reinit_rst", {15'h0, REINIT_RST}, {15'h0, reinit_needed});
        @(posedge clk);
        #10;
        rst_n = 1'b1;
        chk("dq_core_rst", core_dq_out, dq_out);
        @(posedge clk);
        #10;
        chk("reinit_after_rst", 16'h0, {15'h0, reinit_needed});
        cs_req_n = 1'b1;
        $display("test mid reset done");
    endtask : t_reset_mid

    task summarize;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    // reset for 16 cycles, then the scenarios
    initial begin
        repeat (16) @(posedge clk);
        #10;
        rst_n = 1'b1;
        @(posedge clk);
        #10;
        t_pattern();
        @(posedge clk);
        #10;
        t_release();
        t_reinit();
        if (timed_out == 0) begin
            t_reset_mid();
        end
        summarize();
    end
endmodule : dct_continuity_test_tb_top
